// ---- pkg/prf_pkg.sv ----
/*
  Shared constants and carrier types of the paged register file.
  Assumes a single core clock domain and an 8-bit register address/data bus.
*/
`default_nettype none

package prf_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int GRP_COUNT = 15;       // groups 0..e, all directly addressable but group d
  localparam int GPR_COUNT = 224;      // groups 0..d
  localparam int RF_DEPTH = 240;       // groups 0..e held in local storage
  localparam int NUM_PAGES = 64;
  localparam int PAGE_W = 6;
  localparam int WIDX_W = 4;           // working register index 0..15

  // ----------------------------------------------------------------
  // group codes (upper nibble of a register number)
  // ----------------------------------------------------------------
  localparam logic [3:0] GRP_D = 4'hd;
  localparam logic [3:0] GRP_E = 4'he;
  localparam logic [3:0] GRP_F = 4'hf;

  // ----------------------------------------------------------------
  // system register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PAGE_SEL = 8'hea;
  localparam logic [7:0] OFS_WPTR0 = 8'he8;
  localparam logic [7:0] OFS_WPTR1 = 8'he9;
  localparam logic [7:0] RST_PAGE_SEL = 8'h00;
  localparam logic [7:0] RST_WPTR = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;

  // ----------------------------------------------------------------
  // pointer register field layout
  // ----------------------------------------------------------------
  localparam int PTR_SPLIT_BIT = 2;    // 1: two blocks of 8, 0: one block of 16
  localparam int PTR_BASE16_LSB = 4;
  localparam int PTR_BASE8_LSB = 3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic working;                     // 1: addr[3:0] is a working index
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } prf_req_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [PAGE_W-1:0] page;
    logic [3:0] idx;
    logic [DATA_W-1:0] wdata;
  } prf_page_t;

  typedef enum logic [3:0] {
    SRC_ZERO = 4'h1,
    SRC_MEM = 4'h2,
    SRC_PAGE = 4'h4,
    SRC_SYS = 4'h8
  } prf_src_t;

endpackage

`default_nettype wire

// ---- rtl/prf_mem.sv ----
/*
  Byte storage for groups 0..e, one write and one registered read port.
  Assumes the caller never addresses beyond DEPTH-1; the array has no reset.
*/
`default_nettype none

module prf_mem
  import prf_pkg::*;
#(
  parameter int DEPTH = RF_DEPTH,
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic re_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [DW-1:0] rdata_out
);

  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rdata_q;

  // ----------------------------------------------------------------
  // storage, left uninitialised so it maps onto plain ram cells
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // read data held in a flop so the output is glitch free
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= '0;
    end else if (re_in) begin
      rdata_q <= mem_q[raddr_in];
    end
  end

  assign rdata_out = rdata_q;

endmodule

`default_nettype wire

// ---- rtl/prf_top.sv ----
/*
  Paged register file: 224 general bytes, system group e, group f window
  onto one of 64 peripheral pages, working register relocation.
  Assumes the core issues at most one request per clock on req_in and that
  peripherals answer a page read combinationally in the same cycle.
*/
`default_nettype none

// Function
// - 240 byte registers in 15 groups, all but group d direct, plus a 16-byte paged group f.
// - groups 0 to d give 224 general purpose storage bytes.
// - group e system registers reachable by direct and working references.
// - group f accesses go to the page chosen by the page select register.
// - page selection stays until rewritten; consecutive page accesses need no rewrite.
// - only implemented pages respond, each always at the same page and slot.
// - group d only through working references; direct group d access is refused.
// - a direct reference is a plain 8-bit register number.
// - working operands give a 4-bit index resolved through pointer registers.
// - working set is one block of 16 or two blocks of 8.
// - core reaches the file over separate 8-bit address and data buses.

module prf_top
  import prf_pkg::*;
#(
  parameter logic [NUM_PAGES-1:0] PAGE_PRESENT = {NUM_PAGES{1'b1}}
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire prf_req_t req_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic rvalid_out,
  output logic refused_out,
  output prf_page_t page_out,
  input wire logic [DATA_W-1:0] page_rdata_in
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] grp_of(input logic [ADDR_W-1:0] a);
    grp_of = a[ADDR_W-1:ADDR_W-4];
  endfunction

  logic [DATA_W-1:0] page_sel_q;
  logic [DATA_W-1:0] wptr0_q;
  logic [DATA_W-1:0] wptr1_q;
  logic [ADDR_W-1:0] eff_addr;
  logic [WIDX_W-1:0] widx;
  logic refuse;
  logic to_page;
  logic page_ok;
  logic to_mem;
  logic is_sys;
  logic mem_we;
  logic mem_re;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] sys_rdata;
  logic [DATA_W-1:0] page_rd_q;
  logic [DATA_W-1:0] sys_rd_q;
  prf_src_t src_d;
  prf_src_t src_q;
  logic rvalid_q;
  logic refused_q;

  // ----------------------------------------------------------------
  // address resolution
  // ----------------------------------------------------------------
  // working index resolution
  always_comb begin
    widx = req_in.addr[WIDX_W-1:0];
    if (!req_in.working) begin
      eff_addr = req_in.addr;
    end else if (!wptr0_q[PTR_SPLIT_BIT]) begin
      eff_addr = {wptr0_q[DATA_W-1:PTR_BASE16_LSB], widx};
    end else if (!widx[WIDX_W-1]) begin
      eff_addr = {wptr0_q[DATA_W-1:PTR_BASE8_LSB], widx[2:0]};
    end else begin
      eff_addr = {wptr1_q[DATA_W-1:PTR_BASE8_LSB], widx[2:0]};
    end
  end

  assign refuse = req_in.valid && !req_in.working && (grp_of(req_in.addr) == GRP_D);
  assign to_page = req_in.valid && !refuse && (grp_of(eff_addr) == GRP_F);
  assign page_ok = PAGE_PRESENT[page_sel_q[PAGE_W-1:0]];
  assign to_mem = req_in.valid && !refuse && (grp_of(eff_addr) != GRP_F);
  // pointer and page registers read from their flops
  assign is_sys = (eff_addr == OFS_PAGE_SEL) || (eff_addr == OFS_WPTR0)
                  || (eff_addr == OFS_WPTR1);
  assign mem_we = to_mem && req_in.write;
  assign mem_re = to_mem && !req_in.write;

  // ----------------------------------------------------------------
  // peripheral page port
  // ----------------------------------------------------------------
  // the page number is taken from the held selector, never from the request
  always_comb begin
    page_out.sel = to_page && page_ok;
    page_out.write = req_in.write;
    page_out.page = page_sel_q[PAGE_W-1:0];
    page_out.idx = eff_addr[3:0];
    page_out.wdata = req_in.wdata;
  end

  // ----------------------------------------------------------------
  // system registers that steer the block
  // ----------------------------------------------------------------
  // page select persists
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      page_sel_q <= RST_PAGE_SEL;
    end else if (mem_we && (eff_addr == OFS_PAGE_SEL)) begin
      page_sel_q <= req_in.wdata;
    end
  end

  // pointer registers; a new pointer applies to the very next request
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wptr0_q <= RST_WPTR;
      wptr1_q <= RST_WPTR;
    end else begin
      if (mem_we && (eff_addr == OFS_WPTR0)) begin
        wptr0_q <= req_in.wdata;
      end
      if (mem_we && (eff_addr == OFS_WPTR1)) begin
        wptr1_q <= req_in.wdata;
      end
    end
  end

  always_comb begin
    case (eff_addr)
      OFS_PAGE_SEL: sys_rdata = page_sel_q;
      OFS_WPTR0: sys_rdata = wptr0_q;
      default: sys_rdata = wptr1_q;
    endcase
  end

  // ----------------------------------------------------------------
  // storage for groups 0..e
  // ----------------------------------------------------------------
  // general purpose storage
  prf_mem #(
    .DEPTH(RF_DEPTH),
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_mem (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .we_in(mem_we),
    .waddr_in(eff_addr),
    .wdata_in(req_in.wdata),
    .re_in(mem_re),
    .raddr_in(eff_addr),
    .rdata_out(mem_rdata)
  );

  // ----------------------------------------------------------------
  // response path
  // ----------------------------------------------------------------
  // pick where the answer of this request will come from
  always_comb begin
    if (!req_in.valid || req_in.write || refuse) begin
      src_d = SRC_ZERO;
    end else if (to_page) begin
      src_d = page_ok ? SRC_PAGE : SRC_ZERO;
    end else if (is_sys) begin
      src_d = SRC_SYS;
    end else begin
      src_d = SRC_MEM;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      src_q <= SRC_ZERO;
    end else begin
      src_q <= src_d;
    end
  end

  // capture side data so every answer leaves from a flop
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      page_rd_q <= RST_DATA;
      sys_rd_q <= RST_DATA;
    end else begin
      if (src_d == SRC_PAGE) begin
        page_rd_q <= page_rdata_in;
      end
      if (src_d == SRC_SYS) begin
        sys_rd_q <= sys_rdata;
      end
    end
  end

  // one answer per request, one cycle later
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rvalid_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      rvalid_q <= req_in.valid;
      refused_q <= refuse;
    end
  end

  always_comb begin
    case (src_q)
      SRC_MEM: rdata_out = mem_rdata;
      SRC_PAGE: rdata_out = page_rd_q;
      SRC_SYS: rdata_out = sys_rd_q;
      default: rdata_out = RST_DATA;
    endcase
  end

  assign rvalid_out = rvalid_q;
  assign refused_out = refused_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  resp_one_cycle_a: assert property (
    req_in.valid |=> rvalid_out ##1 (rvalid_out == $past(req_in.valid)))
    else $error("answer not one cycle after request");

  direct_d_refused_a: assert property (
    (req_in.valid && !req_in.working && req_in.addr[7:4] == GRP_D)
      |-> (!mem_we && !page_out.sel) ##1 (refused_out && rdata_out == 8'h00))
    else $error("direct group d access not refused");

  working_d_ok_a: assert property (
    (req_in.valid && req_in.working && eff_addr[7:4] == GRP_D) |=> !refused_out)
    else $error("working group d access refused");

  page_steer_a: assert property (
    (req_in.valid && req_in.working == 1'b0 && req_in.addr[7:4] == GRP_F && page_ok)
      |-> (page_out.sel && page_out.page == page_sel_q[5:0]
           && page_out.idx == req_in.addr[3:0] && !mem_we))
    else $error("group f access not steered to page");

  page_persist_a: assert property (
    $changed(page_sel_q) |-> $past(mem_we && eff_addr == 8'hea))
    else $error("page select changed without a write");

  page_absent_a: assert property (
    page_out.sel |-> PAGE_PRESENT[page_out.page])
    else $error("absent page selected");

  single_block_a: assert property (
    (req_in.valid && req_in.working && !wptr0_q[2])
      |-> eff_addr == {wptr0_q[7:4], req_in.addr[3:0]})
    else $error("single block relocation wrong");

  split_block_a: assert property (
    (req_in.valid && req_in.working && wptr0_q[2] && req_in.addr[3])
      |-> eff_addr == {wptr1_q[7:3], req_in.addr[2:0]})
    else $error("upper half block relocation wrong");

  split_lower_a: assert property (
    (req_in.valid && req_in.working && wptr0_q[2] && !req_in.addr[3])
      |-> eff_addr == {wptr0_q[7:3], req_in.addr[2:0]})
    else $error("lower half block relocation wrong");

  absent_read_a: assert property (
    (req_in.valid && !req_in.write && !req_in.working
     && req_in.addr[7:4] == GRP_F && !page_ok)
      |=> rdata_out == 8'h00)
    else $error("absent page read not zero");

  direct_plain_a: assert property (
    (req_in.valid && !req_in.working) |-> eff_addr == req_in.addr)
    else $error("direct number altered");

  page_write_a: assert property (
    (req_in.valid && req_in.write && req_in.working && eff_addr == 8'hea)
      |=> page_sel_q == $past(req_in.wdata))
    else $error("working write to page select lost");

  readback_a: assert property (
    (req_in.valid && req_in.write && !req_in.working && req_in.addr < 8'hd0)
      ##1 (req_in.valid && !req_in.write && !req_in.working
           && req_in.addr == $past(req_in.addr))
      |=> rdata_out == $past(req_in.wdata, 2))
    else $error("write not visible to next read");

  split_use_c: cover property (req_in.valid && req_in.working && wptr0_q[2]);
  page_read_c: cover property (page_out.sel && !page_out.write ##1 rvalid_out);
  refuse_c: cover property (refused_out);
  page_write_c: cover property (page_out.sel && page_out.write);

endmodule

`default_nettype wire

// ---- tb/paged_register_file_tb_top.sv ----
/*
  Self-checking bench of the paged register file, driving the core bus.
  Assumes prf_pkg and the design are compiled first; page 3 is left absent.
*/
`default_nettype none

module paged_register_file_tb_top
  import prf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam logic [NUM_PAGES-1:0] PRESENT = ~(64'h1 << 3);
  logic clk_in;
  logic reset_in;
  prf_req_t req;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  logic refused;
  prf_page_t page;
  logic [DATA_W-1:0] page_rdata;
  logic [7:0] gpr_a [5];
  int error_cnt;
  int total_checks;

  prf_top #(.PAGE_PRESENT(PRESENT)) u_prf_top (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .req_in(req),
    .rdata_out(rdata),
    .rvalid_out(rvalid),
    .refused_out(refused),
    .page_out(page),
    .page_rdata_in(page_rdata)
  );

  prf_page_model u_prf_page_model (
    .clk_in(clk_in),
    .page_in(page),
    .rdata_out(page_rdata)
  );

  // 100 mhz core clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one request, held for exactly the taking edge, answer read one cycle later
  task automatic xfer(input logic wr, input logic wk, input logic [7:0] a,
                      input logic [7:0] d, input logic [7:0] exp_rd,
                      input logic exp_ref, input logic exp_sel);
    @(posedge clk_in);
    #1;
    req = '{valid: 1'b1, write: wr, working: wk, addr: a, wdata: d};
    #1;
    check("page strobe", {7'h00, page.sel}, {7'h00, exp_sel});
    if (exp_sel) check("page slot", {4'h0, page.idx}, {4'h0, a[3:0]});
    @(posedge clk_in);
    #1;
    req.valid = 1'b0;
    check("answer strobe", {7'h00, rvalid}, 8'h01);
    check("refusal", {7'h00, refused}, {7'h00, exp_ref});
    check("read data", rdata, exp_rd);
  endtask

  // direct write then read of one byte on back to back edges, valid held high
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    req = '{valid: 1'b1, write: 1'b1, working: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    #1;
    req.write = 1'b0;
    check("pair write strobe", {7'h00, rvalid}, 8'h01);
    check("pair write data", rdata, 8'h00);
    @(posedge clk_in);
    #1;
    req.valid = 1'b0;
    check("pair read strobe", {7'h00, rvalid}, 8'h01);
    check("pair read data", rdata, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s = 1'b0);
    xfer(1'b1, 1'b0, a, d, 8'h00, 1'b0, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic s = 1'b0);
    xfer(1'b0, 1'b0, a, 8'h00, e, 1'b0, s);
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the length of the sequence
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    total_checks = 0;
    req = '0;
    reset_in = 1'b1;
    gpr_a = '{8'h00, 8'h0f, 8'h10, 8'h7f, 8'hcf};
    repeat (20) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    // pointers and page select start at zero
    rd(OFS_PAGE_SEL, RST_PAGE_SEL);
    rd(OFS_WPTR0, RST_WPTR);
    rd(OFS_WPTR1, RST_WPTR);
    // group edges of general storage
    for (int i = 0; i < 5; i++) wr(gpr_a[i], ~gpr_a[i]);
    for (int i = 0; i < 5; i++) rd(gpr_a[i], ~gpr_a[i]);
    // a read on the edge right after the write already sees the new byte
    wr_rd(8'h55, 8'hc3);
    // group d: working access works, direct access refused and harmless
    wr(OFS_WPTR0, 8'hd0);
    xfer(1'b1, 1'b1, 8'h05, 8'h66, 8'h00, 1'b0, 1'b0);
    xfer(1'b1, 1'b0, 8'hd5, 8'h5a, 8'h00, 1'b1, 1'b0);
    xfer(1'b0, 1'b1, 8'h05, 8'h00, 8'h66, 1'b0, 1'b0);
    xfer(1'b0, 1'b0, 8'hd5, 8'h00, 8'h00, 1'b1, 1'b0);
    // group e by plain number and by working index
    wr(8'he7, 8'h3c);
    rd(8'he7, 8'h3c);
    wr(OFS_WPTR0, 8'he0);
    xfer(1'b0, 1'b1, 8'h07, 8'h00, 8'h3c, 1'b0, 1'b0);
    xfer(1'b0, 1'b1, 8'h0a, 8'h00, 8'h00, 1'b0, 1'b0);
    // page select written through a working index lands in the selector
    xfer(1'b1, 1'b1, 8'h0a, 8'h07, 8'h00, 1'b0, 1'b0);
    rd(OFS_PAGE_SEL, 8'h07);
    // split mode: index 2 via base 28, index 9 via base 48
    wr(OFS_WPTR0, 8'h2c);
    wr(OFS_WPTR1, 8'h48);
    xfer(1'b1, 1'b1, 8'h02, 8'h11, 8'h00, 1'b0, 1'b0);
    xfer(1'b1, 1'b1, 8'h09, 8'h99, 8'h00, 1'b0, 1'b0);
    rd(8'h2a, 8'h11);
    rd(8'h49, 8'h99);
    // page window: upper select bits kept but ignored for the page number
    wr(OFS_PAGE_SEL, 8'h45);
    rd(OFS_PAGE_SEL, 8'h45);
    wr(8'hf2, 8'ha5, 1'b1);
    wr(OFS_PAGE_SEL, 8'h06);
    wr(8'hf2, 8'h3c, 1'b1);
    wr(OFS_PAGE_SEL, 8'h05);
    rd(8'hf2, 8'ha5, 1'b1);
    rd(8'hf2, 8'ha5, 1'b1);
    wr(OFS_PAGE_SEL, 8'h06);
    rd(8'hf2, 8'h3c, 1'b1);
    wr(OFS_WPTR0, 8'hf0);
    xfer(1'b0, 1'b1, 8'h02, 8'h00, 8'h3c, 1'b0, 1'b1);
    // absent page: no strobe, reads zero
    wr(OFS_PAGE_SEL, 8'h03);
    wr(8'hf1, 8'h77, 1'b0);
    rd(8'hf1, 8'h00, 1'b0);
    // mid-run reset: steering registers return to zero, storage keeps its bytes
    @(posedge clk_in);
    #1;
    reset_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    rd(OFS_PAGE_SEL, RST_PAGE_SEL);
    rd(OFS_WPTR0, RST_WPTR);
    rd(8'h10, 8'hef);
    wrap_up();
  end
endmodule

`default_nettype wire

// ---- tb/prf_page_model.sv ----
/*
  Peripheral side of the group f window: 64 pages of 16 bytes.
  Assumes page_out of the register file drives page_in, one clock domain.
*/
`default_nettype none

module prf_page_model
  import prf_pkg::*;
(
  input wire logic clk_in,
  input wire prf_page_t page_in,
  output logic [DATA_W-1:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // peripheral storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] regs [NUM_PAGES*16];
  logic [DATA_W-1:0] last_q = 8'h00;

  // fixed page and slot
  // a write lands on the strobed edge; reads remember what was shown
  always @(posedge clk_in) begin
    if (page_in.sel && page_in.write) begin
      regs[{page_in.page, page_in.idx}] <= page_in.wdata;
    end
    if (page_in.sel && !page_in.write) begin
      last_q <= rdata_out;
    end
  end

  // 8-bit read answer
  // released bus shows the inverse of the last answer, never a stale copy
  always_comb begin
    if (page_in.sel && !page_in.write) begin
      rdata_out = regs[{page_in.page, page_in.idx}];
    end else begin
      rdata_out = ~last_q;
    end
  end
endmodule

`default_nettype wire
